// [pfws_regs.vh]
// constants for the parallel flash write sequencer host
`ifndef PFWS_REGS_VH
`define PFWS_REGS_VH
`define PFWS_ADDR_W 17
`define PFWS_CMD_NONE 2'h0
`define PFWS_CMD_PROG 2'h1
`define PFWS_CMD_SECT 2'h2
`define PFWS_CMD_CHIP 2'h3
`define PFWS_PROG_WRITES 3'h4
`define PFWS_ERASE_WRITES 3'h6
`define PFWS_SECT_CODE 8'h30
`define PFWS_CHIP_CODE 8'h10
`define PFWS_CHIP_ADDR 17'h05555
`define PFWS_SECT_SHIFT 12
`define PFWS_CLK_MHZ 40
`define PFWS_PROG_MAX_US 30
`define PFWS_PROG_CYC (`PFWS_PROG_MAX_US * `PFWS_CLK_MHZ)
`define PFWS_SETUP_CYC 4'h3
`define PFWS_PULSE_CYC 4'h4
`define PFWS_HOLD_CYC 4'h2
`define PFWS_READ_CYC 4'h4
`endif

// [pfws_unlock_table.v]
// table of unlock writes that precede the final command write
`include "pfws_regs.vh"
module pfws_unlock_table #(
    parameter [16:0] UNLOCK_A0 = 17'h05555,
    parameter [16:0] UNLOCK_A1 = 17'h02AAA,
    parameter [7:0] UNLOCK_D0 = 8'hAA,
    parameter [7:0] UNLOCK_D1 = 8'h55,
    parameter [7:0] PROG_CODE = 8'hA0,
    parameter [7:0] ERASE_CODE = 8'h80
) (
    input wire [1:0] cmd,
    input wire [2:0] step,
    output reg [16:0] addr,
    output reg [7:0] data
);
    // steps 0..4 for erases: A0/D0, A1/D1, A0/ERASE, A0/D0, A1/D1; program: A0/D0, A1/D1, A0/PROG
    always @* begin
        addr = UNLOCK_A0;
        data = UNLOCK_D0;
        case (step)
            3'h0: begin
                addr = UNLOCK_A0;
                data = UNLOCK_D0;
            end
            3'h1, 3'h4: begin
                addr = UNLOCK_A1;
                data = UNLOCK_D1;
            end
            3'h2: begin
                addr = UNLOCK_A0;
                data = (cmd == `PFWS_CMD_PROG) ? PROG_CODE : ERASE_CODE;
            end
            default: begin
                addr = UNLOCK_A0;
                data = UNLOCK_D0;
            end
        endcase
    end
endmodule

// [pfws_host.v]
// host sequencer that programs and erases a byte-wide parallel flash by its pins
`include "pfws_regs.vh"
module pfws_host (
    input wire sys_clk,
    input wire rstn,
    input wire [1:0] op_cmd,
    input wire op_start,
    input wire [16:0] op_addr,
    input wire [7:0] op_data,
    output reg op_busy,
    output reg op_done,
    output reg op_error,
    output reg flash_ce_n,
    output reg flash_oe_n,
    output reg flash_we_n,
    output reg [16:0] flash_addr,
    output reg [7:0] flash_dq_out,
    output reg flash_dq_oe,
    input wire [7:0] flash_dq_in
);
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_SETUP = 3'h1;
    localparam [2:0] ST_PULSE = 3'h2;
    localparam [2:0] ST_HOLD = 3'h3;
    localparam [2:0] ST_RSET = 3'h4;
    localparam [2:0] ST_RWAIT = 3'h5;
    localparam [2:0] ST_RGAP = 3'h6;
    localparam [2:0] ST_FIN = 3'h7;
    localparam [31:0] PROG_CYC = `PFWS_PROG_CYC;

    reg [2:0] st_q;
    reg [1:0] cmd_q;
    reg [2:0] step_q;
    reg [3:0] cnt_q;
    reg [16:0] tgt_addr_q;
    reg [7:0] tgt_data_q;
    reg [7:0] dq_s1_q;
    reg [7:0] dq_s2_q;
    reg [1:0] confirm_q;
    reg [15:0] tmo_q;
    reg timeout_flag_q;
    wire [16:0] tbl_addr;
    wire [7:0] tbl_data;

    pfws_unlock_table u_table (
        .cmd(cmd_q),
        .step(step_q),
        .addr(tbl_addr),
        .data(tbl_data)
    );

    // last write of the sequence carries target or command code
    function last_step;
        input [1:0] c;
        input [2:0] s;
        begin
            last_step = (c == `PFWS_CMD_PROG) ? (s == `PFWS_PROG_WRITES - 3'h1)
                                               : (s == `PFWS_ERASE_WRITES - 3'h1);
        end
    endfunction

    // status is done when poll bit matches expected final value
    function poll_done;
        input [1:0] c;
        input [7:0] rd;
        input [7:0] exp;
        begin
            if (c == `PFWS_CMD_PROG)
                poll_done = (rd[7] == exp[7]);
            else
                poll_done = rd[7];
        end
    endfunction

    // final write fields per command
    reg [16:0] wr_addr;
    reg [7:0] wr_data;
    always @* begin
        wr_addr = tbl_addr;
        wr_data = tbl_data;
        if (last_step(cmd_q, step_q)) begin
            case (cmd_q)
                `PFWS_CMD_PROG: begin
                    wr_addr = tgt_addr_q;
                    wr_data = tgt_data_q;
                end
                `PFWS_CMD_SECT: begin
                    wr_addr = {tgt_addr_q[16:`PFWS_SECT_SHIFT], 12'h000};
                    wr_data = `PFWS_SECT_CODE;
                end
                `PFWS_CMD_CHIP: begin
                    wr_addr = `PFWS_CHIP_ADDR;
                    wr_data = `PFWS_CHIP_CODE;
                end
                default: begin
                    wr_addr = tbl_addr;
                    wr_data = tbl_data;
                end
            endcase
        end
    end

    // flash data pins are asynchronous to sys_clk
    always @(posedge sys_clk) begin
        if (!rstn) begin
            dq_s1_q <= 8'h00;
            dq_s2_q <= 8'h00;
        end else begin
            dq_s1_q <= flash_dq_in;
            dq_s2_q <= dq_s1_q;
        end
    end

    always @(posedge sys_clk) begin
        if (!rstn) begin
            st_q <= ST_IDLE;
            cmd_q <= `PFWS_CMD_NONE;
            step_q <= 3'h0;
            cnt_q <= 4'h0;
            tgt_addr_q <= 17'h00000;
            tgt_data_q <= 8'h00;
            confirm_q <= 2'h0;
            tmo_q <= 16'h0000;
            timeout_flag_q <= 1'b0;
            op_busy <= 1'b0;
            op_done <= 1'b0;
            op_error <= 1'b0;
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
            flash_addr <= 17'h00000;
            flash_dq_out <= 8'h00;
            flash_dq_oe <= 1'b0;
        end else begin
            op_done <= 1'b0;
            cnt_q <= cnt_q + 4'h1;
            if (st_q == ST_RSET || st_q == ST_RWAIT || st_q == ST_RGAP) begin
                tmo_q <= tmo_q + 16'h0001;
                if (cmd_q == `PFWS_CMD_PROG && {16'h0000, tmo_q} >= PROG_CYC)
                    timeout_flag_q <= 1'b1;
            end
            case (st_q)
                ST_IDLE: begin
                    if (op_start && op_cmd != `PFWS_CMD_NONE) begin
                        cmd_q <= op_cmd;
                        tgt_addr_q <= op_addr;
                        tgt_data_q <= op_data;
                        step_q <= 3'h0;
                        cnt_q <= 4'h0;
                        tmo_q <= 16'h0000;
                        timeout_flag_q <= 1'b0;
                        confirm_q <= 2'h0;
                        op_busy <= 1'b1;
                        op_error <= 1'b0;
                        st_q <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    // output gate stays high so the write is not inhibited
                    flash_oe_n <= 1'b1;
                    flash_ce_n <= 1'b0;
                    flash_addr <= wr_addr;
                    flash_dq_out <= wr_data;
                    flash_dq_oe <= 1'b1;
                    if (cnt_q == `PFWS_SETUP_CYC) begin
                        flash_we_n <= 1'b0;
                        cnt_q <= 4'h0;
                        st_q <= ST_PULSE;
                    end
                end
                ST_PULSE: begin
                    if (cnt_q == `PFWS_PULSE_CYC) begin
                        flash_we_n <= 1'b1;
                        cnt_q <= 4'h0;
                        st_q <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (cnt_q == `PFWS_HOLD_CYC) begin
                        flash_ce_n <= 1'b1;
                        flash_dq_oe <= 1'b0;
                        cnt_q <= 4'h0;
                        if (last_step(cmd_q, step_q)) begin
                            // only status polls from here on; no new commands
                            st_q <= ST_RSET;
                        end else begin
                            step_q <= step_q + 3'h1;
                            st_q <= ST_SETUP;
                        end
                    end
                end
                ST_RSET: begin
                    flash_dq_oe <= 1'b0;
                    flash_addr <= (cmd_q == `PFWS_CMD_CHIP) ? `PFWS_CHIP_ADDR : tgt_addr_q;
                    flash_ce_n <= 1'b0;
                    flash_oe_n <= 1'b0;
                    cnt_q <= 4'h0;
                    st_q <= ST_RWAIT;
                end
                ST_RWAIT: begin
                    // read strobe time only; the two synchroniser stages are waited out in ST_RGAP
                    if (cnt_q == `PFWS_READ_CYC) begin
                        flash_ce_n <= 1'b1;
                        flash_oe_n <= 1'b1;
                        cnt_q <= 4'h0;
                        st_q <= ST_RGAP;
                    end
                end
                ST_RGAP: begin
                    // sample taken once pins are settled through the synchroniser
                    if (cnt_q == 4'h1) begin
                        if (poll_done(cmd_q, dq_s2_q, tgt_data_q)) begin
                            // a pass after a mismatch needs two more passes
                            if (confirm_q == 2'h0 || confirm_q == 2'h3)
                                st_q <= ST_FIN;
                            else begin
                                confirm_q <= confirm_q + 2'h1;
                                st_q <= ST_RSET;
                            end
                        end else begin
                            confirm_q <= 2'h1;
                            if (timeout_flag_q) begin
                                op_error <= 1'b1;
                                st_q <= ST_FIN;
                            end else
                                st_q <= ST_RSET;
                        end
                    end
                end
                ST_FIN: begin
                    op_busy <= 1'b0;
                    op_done <= 1'b1;
                    cmd_q <= `PFWS_CMD_NONE;
                    st_q <= ST_IDLE;
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end
endmodule

// [pfws_host_sva.sv]
// assertions on the port timing of the flash host sequencer
module pfws_host_sva (
    input wire sys_clk,
    input wire rstn,
    input wire [1:0] op_cmd,
    input wire op_start,
    input wire op_busy,
    input wire op_done,
    input wire flash_ce_n,
    input wire flash_oe_n,
    input wire flash_we_n,
    input wire [16:0] flash_addr,
    input wire [7:0] flash_dq_out,
    input wire flash_dq_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    chk_we_under_ce: assert property (!flash_we_n |-> !flash_ce_n)
        else $error("strobe low without select");
    chk_we_width: assert property ($fell(flash_we_n) |-> !flash_we_n[*5] ##1 flash_we_n)
        else $error("strobe width wrong");
    chk_no_we_oe: assert property (!flash_we_n |-> flash_oe_n)
        else $error("strobe low with output gate");
    chk_read_release: assert property (!flash_oe_n |-> !flash_ce_n && !flash_dq_oe)
        else $error("read without release");
    chk_wr_stable: assert property (!flash_we_n |-> $stable(flash_addr) && $stable(flash_dq_out) && flash_dq_oe)
        else $error("write lines moved");
    chk_start_busy: assert property (op_start && !op_busy && op_cmd != 2'h0 |=> op_busy)
        else $error("start not taken");
    chk_done_pulse: assert property (op_done |=> !op_done && !op_busy)
        else $error("done not a pulse");
    chk_idle_quiet: assert property (!op_busy |-> flash_ce_n && flash_we_n)
        else $error("bus active while idle");
endmodule
bind pfws_host pfws_host_sva u_sva (.sys_clk, .rstn, .op_cmd, .op_start, .op_busy, .op_done,
    .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_addr, .flash_dq_out, .flash_dq_oe);

// [pfws_flash_model.sv]
// behavioural byte-wide flash device on the far side of the host
module pfws_flash_model #(
    parameter int PROG_NS = 8000,
    parameter int ERASE_NS = 15000
) (
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [16:0] addr,
    input wire logic [7:0] dq_w,
    input wire logic dq_oe,
    input wire logic slow,
    output logic [7:0] dq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [int];
    logic [16:0] a_q, last_a;
    logic [7:0] last_d, rd_q, pd_q;
    logic busy = 1'b0, ers_q = 1'b0, ers_b = 1'b0, tgl = 1'b0;
    int n = 0;
    int wr_cnt = 0;
    int idle_rd = 0;
    wire wr = !ce_n && !we_n && oe_n;
    wire rd = !ce_n && !oe_n;
    // released bus shows the inverse so a stale value cannot pass
    assign dq = dq_oe ? dq_w : (rd ? rd_q : ~rd_q);
    task automatic launch(input int t, input logic e);
        busy = 1'b1;
        ers_b = e;
        tgl = 1'b0;
        n = 0;
        busy <= #(t) 1'b0;
    endtask
    always @(posedge wr) a_q = addr;
    always @(negedge wr) begin
        if (!busy) begin
            wr_cnt++;
            last_a = a_q;
            last_d = dq_w;
            if (n == 3 && !ers_q) begin
                mem[a_q] = (mem.exists(a_q) ? mem[a_q] : 8'hFF) & dq_w;
                pd_q = dq_w;
                launch(slow ? 40000 : PROG_NS, 1'b0);
            end else if (n == 5 && dq_w == 8'h10 && a_q == 17'h05555) begin
                mem.delete();
                launch(ERASE_NS, 1'b1);
            end else if (n == 5 && dq_w == 8'h30) begin
                for (int k = 0; k < 4096; k++) mem.delete({a_q[16:12], 12'h000} + k);
                launch(ERASE_NS, 1'b1);
            end else if (n < 5 && (n % 3 == 0 ? a_q == 17'h05555 && dq_w == 8'hAA :
                    n % 3 == 1 ? a_q == 17'h02AAA && dq_w == 8'h55 :
                    a_q == 17'h05555 && (dq_w == 8'hA0 || dq_w == 8'h80))) begin
                if (n == 2) ers_q = (dq_w == 8'h80);
                n++;
            end else n = 0;
        end
    end
    always @(posedge rd) begin
        if (busy) begin
            tgl = !tgl;
            rd_q = {ers_b ? 1'b0 : ~pd_q[7], tgl, 6'h00};
        end else begin
            idle_rd++;
            rd_q = mem.exists(addr) ? mem[addr] : 8'hFF;
        end
    end
endmodule

// [tb_top.sv]
// self-checking bench for the flash host sequencer
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0, rstn = 1'b0, op_start = 1'b0, slow = 1'b0;
    logic [1:0] op_cmd = 2'h0;
    logic [16:0] op_addr = 17'h00000;
    logic [7:0] op_data = 8'h00;
    logic op_busy, op_done, op_error, ce_n, oe_n, we_n, dq_oe;
    logic [16:0] f_addr;
    logic [7:0] dq_out, dq;
    int error_cnt = 0;
    int checks = 0;
    always #12.5 sys_clk = ~sys_clk;
    pfws_host u_dut (.sys_clk(sys_clk), .rstn(rstn), .op_cmd(op_cmd), .op_start(op_start),
        .op_addr(op_addr), .op_data(op_data), .op_busy(op_busy), .op_done(op_done),
        .op_error(op_error), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
        .flash_addr(f_addr), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_dq_in(dq));
    pfws_flash_model u_flash (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(f_addr),
        .dq_w(dq_out), .dq_oe(dq_oe), .slow(slow), .dq(dq));
    task automatic chk(input logic ok, input string m);
        checks++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task automatic run(input logic [1:0] c, input logic [16:0] a, input logic [7:0] d);
        u_flash.wr_cnt = 0;
        u_flash.idle_rd = 0;
        @(posedge sys_clk);
        op_cmd <= c;
        op_addr <= a;
        op_data <= d;
        op_start <= 1'b1;
        @(posedge sys_clk);
        op_start <= 1'b0;
        for (int i = 0; i < 4000 && op_done !== 1'b1; i++) @(posedge sys_clk);
        chk(op_done === 1'b1, "no completion");
    endtask
    task automatic s_prog(input logic [16:0] a, input logic [7:0] d);
        run(2'h1, a, d);
        chk(u_flash.wr_cnt == 4 && u_flash.mem[a] === d, "program");
        chk(u_flash.last_a === a && u_flash.last_d === d, "target write");
        chk(op_error === 1'b0, "false error");
        // a busy poll comes first, so completion takes one pass and two confirming passes
        chk(u_flash.idle_rd == 3, "status confirm");
    endtask
    task automatic s_sect;
        s_prog(17'h01FFF, 8'h3C);
        run(2'h2, 17'h01234, 8'h00);
        chk(u_flash.wr_cnt == 6 && u_flash.last_d === 8'h30, "sector code");
        chk(u_flash.last_a === 17'h01000, "sector address");
        chk(!u_flash.mem.exists(17'h01FFF) && u_flash.mem.exists(17'h00123), "sector span");
    endtask
    task automatic s_chip;
        run(2'h3, 17'h00777, 8'h00);
        chk(u_flash.wr_cnt == 6 && u_flash.last_d === 8'h10, "chip code");
        chk(u_flash.last_a === 17'h05555 && u_flash.mem.num() == 0, "chip erase");
    endtask
    task automatic s_ignore;
        fork
            run(2'h1, 17'h00040, 8'h81);
            begin
                repeat (30) @(posedge sys_clk);
                op_cmd <= 2'h3;
                op_start <= 1'b1;
                @(posedge sys_clk);
                op_start <= 1'b0;
            end
        join
        chk(u_flash.wr_cnt == 4 && u_flash.mem.exists(17'h00123), "start while busy");
    endtask
    task automatic s_slow;
        slow = 1'b1;
        run(2'h1, 17'h00200, 8'h0F);
        chk(op_error === 1'b1, "no timeout flag");
        slow = 1'b0;
        // the slow byte still completes in the model before the next command
        repeat (500) @(posedge sys_clk);
        s_prog(17'h00300, 8'hF0);
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        end_of_test();
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        s_prog(17'h00123, 8'h5A);
        s_prog(17'h1FFFF, 8'hC3);
        s_sect();
        s_ignore();
        s_slow();
        s_chip();
        end_of_test();
    end
endmodule
